// ---- hss_regs.vh ----
// hardware standby sequencer constants: state codes, reset sequence length, pin sync reset values
// assumes inclusion by hss_sequencer.v only
`ifndef HSS_REGS_VH
`define HSS_REGS_VH
// ==========================================
// sequencer state encodings
`define HSS_ST_RUN 3'h0
`define HSS_ST_STANDBY 3'h1
`define HSS_ST_OSC_WAKE 3'h2
`define HSS_ST_RESET_SEQ 3'h3
`define HSS_ST_RESET_HOLD 3'h4
// ==========================================
// reset sequence length in cycles
`define HSS_RESET_SEQ_CYCLES 8'h08
// ==========================================
// power-on values of the halt and mode pin synchronisers (inactive)
`define HSS_SYNC_RESET 3'h7
`define HSS_MODE_SYNC_RESET 3'h7
`endif

// ---- hss_sequencer.v ----
// hardware standby sequencer: pin-driven standby entry and two-pin recovery
// assumes the standby, reset and mode pins arrive asynchronously to CLK_SYS
//
// Notes on behaviour
// - standby pin low forces standby from every state
// - in standby the cpu halts, peripherals stop, ports float
// - entering standby returns peripheral registers to initial values
// - on-chip ram contents are kept; nothing else survives standby
// - both mode pins low in standby selects prom programming mode
// - standby release restarts the oscillator; reset release still needed
// - reset rising after standby release runs reset sequence, then program
`timescale 1ns/100ps
`include "hss_regs.vh"
module hss_sequencer #(
  parameter RESET_SEQ_CYCLES = `HSS_RESET_SEQ_CYCLES
) (
  input wire CLK_SYS,
  input wire RSTN,
  input wire HW_HALT_REQUEST_N,
  input wire CHIP_INIT_PIN_N,
  input wire BOOT_MODE_SELECT_HI,
  input wire BOOT_MODE_SELECT_LO,
  input wire ONCHIP_RAM_ENABLE,
  output reg CPU_RUN,
  output reg PERIPH_CLOCK_EN,
  output reg PERIPH_RESET_N,
  output reg PORT_OE_N,
  output reg OSC_ENABLE,
  output reg RAM_ACCESS_EN,
  output reg RAM_RETAIN,
  output reg PROM_MODE,
  output reg IN_STANDBY
);
  // ==========================================
  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  reg [2:0] halt_sync;
  reg [2:0] init_sync;
  reg [2:0] mhi_sync;
  reg [2:0] mlo_sync;
  reg halt_n;
  reg init_n;
  reg mode_hi;
  reg mode_lo;

  // two-sample agreement filter: keep the held level until stages 2 and 3 agree
  // a one-cycle pulse never shows in both stages at once, so it is dropped
  function sync_filter;
    input [2:0] stages;
    input held;
    begin
      sync_filter = (stages[1] == stages[2]) ? stages[2] : held;
    end
  endfunction

  // all four pins share one synchroniser process so their latency is equal
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      halt_sync <= `HSS_SYNC_RESET;
      init_sync <= 3'h0;
      mhi_sync <= `HSS_MODE_SYNC_RESET;
      mlo_sync <= `HSS_MODE_SYNC_RESET;
      halt_n <= 1'b1;
      init_n <= 1'b0;
      mode_hi <= 1'b1;
      mode_lo <= 1'b1;
    end else begin
      halt_sync <= {halt_sync[1:0], HW_HALT_REQUEST_N};
      init_sync <= {init_sync[1:0], CHIP_INIT_PIN_N};
      mhi_sync <= {mhi_sync[1:0], BOOT_MODE_SELECT_HI};
      mlo_sync <= {mlo_sync[1:0], BOOT_MODE_SELECT_LO};
      // stage 1 is read only by stage 2, so a possibly metastable first sample never reaches the filter
      halt_n <= sync_filter(halt_sync, halt_n);
      init_n <= sync_filter(init_sync, init_n);
      mode_hi <= sync_filter(mhi_sync, mode_hi);
      mode_lo <= sync_filter(mlo_sync, mode_lo);
    end
  end

  // ==========================================
  // sequencer state machine
  localparam ST_RUN = `HSS_ST_RUN;
  localparam ST_STANDBY = `HSS_ST_STANDBY;
  localparam ST_OSC_WAKE = `HSS_ST_OSC_WAKE;
  localparam ST_RESET_SEQ = `HSS_ST_RESET_SEQ;
  localparam ST_RESET_HOLD = `HSS_ST_RESET_HOLD;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] seq_count;
  reg [7:0] next_seq_count;
  always @* begin
    next_state = state;
    next_seq_count = seq_count;
    if (!halt_n) begin
      next_state = ST_STANDBY;
    end else begin
      case (state)
        ST_STANDBY: next_state = ST_OSC_WAKE;
        // leaving ST_OSC_WAKE needs a release of the reset pin, not just halt high
        ST_OSC_WAKE: if (init_n) begin
          next_state = ST_RESET_SEQ;
          next_seq_count = 8'h00;
        end
        ST_RESET_HOLD: if (init_n) begin
          next_state = ST_RESET_SEQ;
          next_seq_count = 8'h00;
        end
        ST_RESET_SEQ: begin
          if (!init_n) begin
            next_state = ST_RESET_HOLD;
          end else if (seq_count == RESET_SEQ_CYCLES[7:0] - 8'h01) begin
            next_state = ST_RUN;
          end else begin
            next_seq_count = seq_count + 8'h01;
          end
        end
        ST_RUN: if (!init_n) next_state = ST_RESET_HOLD;
        default: next_state = ST_RESET_HOLD;
      endcase
    end
  end

  // chip comes out of power-on reset held in reset until the pin releases
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_RESET_HOLD;
      seq_count <= 8'h00;
    end else begin
      state <= next_state;
      seq_count <= next_seq_count;
    end
  end

  // ==========================================
  // registered outputs derived from the next state
  // decoding from next_state keeps every output in step with the state register,
  // at the cost of a longer combinational path into each output flop

  // true when a state code means the core is executing
  function is_run;
    input [2:0] st;
    begin
      is_run = (st == ST_RUN);
    end
  endfunction

  // true when a state code means the chip stands by
  function is_standby;
    input [2:0] st;
    begin
      is_standby = (st == ST_STANDBY);
    end
  endfunction

  // cpu executes only in the run state; reset hold and standby both halt it
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CPU_RUN <= 1'b0;
    end else begin
      CPU_RUN <= is_run(next_state);
    end
  end

  // peripheral clocks stop everywhere but run
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PERIPH_CLOCK_EN <= 1'b0;
    end else begin
      PERIPH_CLOCK_EN <= is_run(next_state);
    end
  end

  // peripherals held in reset in standby and until the reset sequence ends
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PERIPH_RESET_N <= 1'b0;
    end else begin
      PERIPH_RESET_N <= is_run(next_state);
    end
  end

  // ports float in standby; elsewhere the port logic decides direction itself
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PORT_OE_N <= 1'b1;
    end else begin
      PORT_OE_N <= is_standby(next_state);
    end
  end

  // oscillator stops only in standby; settling is left to the supervisor
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      OSC_ENABLE <= 1'b1;
    end else begin
      OSC_ENABLE <= !is_standby(next_state);
    end
  end

  // ram array keeps its contents while the retention supply is held
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RAM_RETAIN <= 1'b0;
    end else begin
      RAM_RETAIN <= is_standby(next_state);
    end
  end

  // ram access gated off outside run, so no stray write can touch kept data
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RAM_ACCESS_EN <= 1'b0;
    end else begin
      RAM_ACCESS_EN <= is_run(next_state) && ONCHIP_RAM_ENABLE;
    end
  end

  // mode pins are meaningful only while standing by; flag only, no other effect
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PROM_MODE <= 1'b0;
    end else begin
      PROM_MODE <= is_standby(next_state) && !mode_hi && !mode_lo;
    end
  end

  // standby status for the rest of the chip and for board debug
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      IN_STANDBY <= 1'b0;
    end else begin
      IN_STANDBY <= is_standby(next_state);
    end
  end
endmodule // hss_sequencer

// ---- hss_sequencer_monitor.sv ----
// checker of standby sequencer pin relations
// bound to hss_sequencer; pins are async levels
`timescale 1ns/100ps
module hss_sequencer_monitor (
  input wire CLK_SYS,
  input wire RSTN,
  input wire HW_HALT_REQUEST_N,
  input wire CHIP_INIT_PIN_N,
  input wire CPU_RUN,
  input wire PERIPH_RESET_N,
  input wire PORT_OE_N,
  input wire OSC_ENABLE,
  input wire RAM_ACCESS_EN,
  input wire RAM_RETAIN,
  input wire PROM_MODE,
  input wire IN_STANDBY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // eight samples cover sync and filter delay with margin
  sequence s_low; !HW_HALT_REQUEST_N [*8]; endsequence
  sequence s_high; HW_HALT_REQUEST_N [*8]; endsequence
  a_standby_entry: assert property (s_low |-> IN_STANDBY) else $error("no standby");
  a_core_halted: assert property (IN_STANDBY |-> !CPU_RUN && PORT_OE_N) else $error("core live");
  a_periph_init: assert property (IN_STANDBY |-> !PERIPH_RESET_N) else $error("periph live");
  a_ram_kept: assert property (IN_STANDBY |-> RAM_RETAIN && !RAM_ACCESS_EN) else $error("ram retain");
  a_prom_flag: assert property (PROM_MODE |-> IN_STANDBY) else $error("prom");
  a_osc_restart: assert property (s_high |-> OSC_ENABLE) else $error("osc off");
  a_run_after_init: assert property ($rose(CPU_RUN) |-> $past(CHIP_INIT_PIN_N, 8)) else $error("early run");
endmodule // hss_sequencer_monitor
bind hss_sequencer hss_sequencer_monitor u_mon (.*);

// ---- hss_supervisor.sv ----
// board supervisor model driving standby, reset, mode, ram enable
// assumes tasks are called from the CLK_SYS domain
`timescale 1ns/100ps
module hss_supervisor (
  input wire clk,
  output reg halt_n = 1'h1,
  output reg init_n = 1'h0,
  output reg [1:0] mode = 2'h3,
  output reg ram_en = 1'h1
);
  // ram enable low first, then reset, then standby; mode held until release
  task enter(input [1:0] m);
    begin
      @(posedge clk) #1 ram_en = 1'h0;
      @(posedge clk) #1 init_n = 1'h0;
      mode = m;
      @(posedge clk) #1 halt_n = 1'h0;
    end
  endtask
  // reset stays low through the settling wait
  task leave(input [7:0] settle, input r);
    begin
      @(posedge clk) #1 halt_n = 1'h1;
      repeat (settle) @(posedge clk);
      #1 init_n = 1'h1;
      ram_en = r;
    end
  endtask
endmodule // hss_supervisor

// ---- tb_hardware_standby_sequencer.sv ----
// bench: random standby cycles through the supervisor model
// assumes the checker binds itself
`timescale 1ns/100ps
module tb_hardware_standby_sequencer;
  reg CLK_SYS = 1'h0;
  reg RSTN = 1'h0;
  integer seed = 67;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer i;
  integer n;
  integer cyc = 0;
  reg [1:0] m;
  wire hn, rn, re;
  wire [1:0] md;
  wire [8:0] q;
  hss_sequencer dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .HW_HALT_REQUEST_N(hn), .CHIP_INIT_PIN_N(rn),
    .BOOT_MODE_SELECT_HI(md[1]), .BOOT_MODE_SELECT_LO(md[0]), .ONCHIP_RAM_ENABLE(re), .CPU_RUN(q[8]),
    .PERIPH_CLOCK_EN(q[7]), .PERIPH_RESET_N(q[6]), .PORT_OE_N(q[5]), .OSC_ENABLE(q[4]),
    .RAM_ACCESS_EN(q[3]), .RAM_RETAIN(q[2]), .PROM_MODE(q[1]), .IN_STANDBY(q[0]));
  hss_supervisor sup (.clk(CLK_SYS), .halt_n(hn), .init_n(rn), .mode(md), .ram_en(re));
  // all nine outputs packed, standby or run picture
  function [8:0] exp_q(input s, input [1:0] mo, input ra);
    exp_q = s ? {7'h09, mo == 2'h0, 1'h1} : {4'hE, 1'h1, ra, 3'h0};
  endfunction
  task check(input [8:0] got, input [8:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial forever #4 CLK_SYS = ~CLK_SYS;
  // hang guard, far above eight rounds
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  // odd rounds cut the reset sequence short with the reset pin, then re-enter standby from reset hold
  initial begin
    repeat (3) @(posedge CLK_SYS);
    #1 RSTN = 1'h1;
    for (i = 0; i < 8; i = i + 1) begin
      sup.leave(8'h08 + ($random(seed) & 8'h0F), $random(seed));
      n = 0;
      while (i % 2 == 0 && q[8] !== 1'h1 && n < 200) begin
        @(posedge CLK_SYS) #1 n = n + 1;
      end
      if (i % 2 == 0) check(q, exp_q(1'h0, md, re));
      if (i % 2 == 0) check({8'h00, n >= 11 && n <= 14}, 9'h001);
      m = (i < 4) ? i : $random(seed);
      sup.enter(m);
      repeat (8) @(posedge CLK_SYS);
      #1 check(q, exp_q(1'h1, m, 1'h0));
      $display("test %0d done", i);
    end
    wrap_up;
  end
endmodule // tb_hardware_standby_sequencer
